// [verilog/msfc_cfg.svh]
// Purpose: Constants for the motion sensor filter configuration block
// Assumes: Byte-wide register port, 100 MHz reference clock
// Notes:   Offsets are byte addresses on the register port
`ifndef MSFC_CFG_SVH
`define MSFC_CFG_SVH
`define MSFC_ADDR_GYRO_CFG     8'h1B
`define MSFC_ADDR_ACC_CFG      8'h1C
`define MSFC_ADDR_ACC_CFG2     8'h1D
`define MSFC_ADDR_RATE_DIV     8'h19
`define MSFC_ADDR_LPF_CFG      8'h1A
`define MSFC_RST_GYRO_CFG      8'h00
`define MSFC_RST_ACC_CFG       8'h00
`define MSFC_RST_ACC_CFG2      8'h00
`define MSFC_RST_RATE_DIV      8'h00
`define MSFC_RST_LPF_CFG       8'h00
`define MSFC_GYRO_RSV_MASK     8'hFB
`define MSFC_ACC_RSV_MASK      8'hF8
`define MSFC_BASE_RATE_NS      1000000
`define MSFC_CLK_PERIOD_NS     10
`define MSFC_BASE_TICK_CYC     (`MSFC_BASE_RATE_NS / `MSFC_CLK_PERIOD_NS)
`endif

// [verilog/msfc_pkg.sv]
// Purpose: Types for the motion sensor filter configuration block
// Assumes: None
// Notes:   Mode enumeration shared by top and divider
package msfc_pkg;
  typedef enum logic [1:0] {MSFC_MODE_GYRO, MSFC_MODE_ACC_NORMAL, MSFC_MODE_ACC_LP} msfc_mode_t;
endpackage

// [verilog/msfc_div_if.sv]
// Purpose: Carrier between the top and the rate divider
// Assumes: Single clock
// Notes:   Top drives the settings, divider drives the sample pulse
`timescale 1ns/1ps
`default_nettype none
interface msfc_div_if;
  logic       enable;
  logic [7:0] divider;
  logic       base_tick;
  logic       sample;
  modport top (output enable, output divider, output base_tick, input sample);
  modport div (input enable, input divider, input base_tick, output sample);
endinterface
`default_nettype wire

// [verilog/msfc_rate_div.sv]
// Purpose: Divides the internal sample tick by one plus the divider value
// Assumes: base_tick is one cycle wide
// Notes:   Passes every tick when not enabled
`timescale 1ns/1ps
`default_nettype none
module msfc_rate_div
  import msfc_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  msfc_div_if.div   bus
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       sample;
  logic       next_sample;

  // Count base ticks and fire on wrap
  always_comb
  begin
    next_count  = count;
    next_sample = 1'b0;
    if (bus.base_tick)
    begin
      if (!bus.enable || count >= bus.divider)
      begin
        next_count  = 8'h00;
        next_sample = 1'b1;
      end
      else
        next_count = count + 8'h01;
    end
  end

  // Register the counter state
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      count  <= 8'h00;
      sample <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      sample <= next_sample;
    end
  end

  assign bus.sample = sample;

  // One output per divider+1 ticks while enabled
  AST_DIV_SPACING: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (bus.enable && bus.base_tick && count == bus.divider && $stable(bus.divider)) |=> sample)
    else $error("divider did not fire on wrap");
  AST_DIV_BYPASS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (!bus.enable && bus.base_tick) |=> sample)
    else $error("divider applied while disabled");
endmodule
`default_nettype wire

// [verilog/msfc_top.sv]
// Purpose: Gyro/accel range, filter and output rate configuration
// Assumes: Host writes bytes through a decoded register port
// Notes:   Unmapped reads return zero
// What this block does
// - Gyro range bits 4:3 pick 250, 500, 1000 or 2000 dps.
// - Gyro filter bits 1:0 are stored inverted; logic inverts before use.
// - Accel range bits 4:3 pick 2g, 4g, 8g or 16g.
// - Depth bits 7:6 pick 512B to 4KB; host resets FIFO after change.
// - Averaging bits 5:4 pick 4, 8, 16 or 32 samples.
// - Accel filter bit 3 inverted; one bypasses filter, ignores bandwidth.
// - Unbypassed, accel bandwidth bits 2:0 pick one of eight settings.
// - Filter output rate is divided by one plus eight-bit divider.
// - Divider applies only at 1 kHz filter path, not in bypass.
// - Low-power accel is duty-cycled, averaging configured first-stage outputs.
// - Any gyro axis on: rate follows gyro filter and low-pass setting.
// - Gyro off, accel normal: rate follows accel filter bit 3 alone.
// - Accel low power: rate also follows accel filter bit 3 alone.
// - Internal rate is 1 kHz; output is that over divider plus one while the divider is active, else 1 kHz.
`timescale 1ns/1ps
`default_nettype none
`include "msfc_cfg.svh"
module msfc_top
  import msfc_pkg::*;
#(
  parameter int BASE_TICK_CYC = `MSFC_BASE_TICK_CYC
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic [2:0] i_gyro_axis_on,
  input  wire logic       i_acc_low_power,
  output logic      [1:0] o_gyro_range_sel,
  output logic      [1:0] o_gyro_fchoice,
  output logic      [1:0] o_acc_range_sel,
  output logic      [1:0] o_fifo_depth_sel,
  output logic      [5:0] o_second_decimator_avg,
  output logic            o_acc_lpf_bypass,
  output logic      [2:0] o_acc_bw_sel,
  output logic      [2:0] o_gyro_selftest_en,
  output logic      [2:0] o_acc_selftest_en,
  output logic            o_acc_duty_cycle,
  output msfc_mode_t      o_mode,
  output logic            o_rate_div_active,
  output logic            o_output_data_rate_strobe,
  output logic            o_fifo_depth_changed
);
  logic [7:0] gyro_range_filter_ctrl, next_gyro_range_filter_ctrl;
  logic [7:0] accel_range_ctrl, next_accel_range_ctrl;
  logic [7:0] accel_filter_fifo_depth_ctrl, next_accel_filter_fifo_depth_ctrl;
  logic [7:0] rate_divider, next_rate_divider;
  logic [7:0] lpf_cfg, next_lpf_cfg;
  logic [7:0] rdata, next_rdata;
  logic       depth_chg, next_depth_chg;
  logic [2:0] gyro_on_s1, gyro_on_s2;
  logic       lp_s1, lp_s2;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic       tick, next_tick;
  msfc_mode_t mode;
  logic       div_en;
  logic [1:0] gyro_fchoice;
  msfc_div_if div_bus ();

  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Register writes and read mux
  always_comb
  begin
    next_gyro_range_filter_ctrl       = gyro_range_filter_ctrl;
    next_accel_range_ctrl             = accel_range_ctrl;
    next_accel_filter_fifo_depth_ctrl = accel_filter_fifo_depth_ctrl;
    next_rate_divider                 = rate_divider;
    next_lpf_cfg                      = lpf_cfg;
    next_depth_chg                    = 1'b0;
    if (i_reg_wr)
    begin
      if (hit(i_reg_addr, `MSFC_ADDR_GYRO_CFG))
        next_gyro_range_filter_ctrl = i_reg_wdata & `MSFC_GYRO_RSV_MASK;
      if (hit(i_reg_addr, `MSFC_ADDR_ACC_CFG))
        next_accel_range_ctrl = i_reg_wdata & `MSFC_ACC_RSV_MASK;
      if (hit(i_reg_addr, `MSFC_ADDR_ACC_CFG2))
      begin
        next_accel_filter_fifo_depth_ctrl = i_reg_wdata;
        next_depth_chg = (i_reg_wdata[7:6] != accel_filter_fifo_depth_ctrl[7:6]);
      end
      if (hit(i_reg_addr, `MSFC_ADDR_RATE_DIV))
        next_rate_divider = i_reg_wdata;
      if (hit(i_reg_addr, `MSFC_ADDR_LPF_CFG))
        next_lpf_cfg = i_reg_wdata;
    end
    if (hit(i_reg_addr, `MSFC_ADDR_GYRO_CFG))
      next_rdata = gyro_range_filter_ctrl;
    else if (hit(i_reg_addr, `MSFC_ADDR_ACC_CFG))
      next_rdata = accel_range_ctrl;
    else if (hit(i_reg_addr, `MSFC_ADDR_ACC_CFG2))
      next_rdata = accel_filter_fifo_depth_ctrl;
    else if (hit(i_reg_addr, `MSFC_ADDR_RATE_DIV))
      next_rdata = rate_divider;
    else if (hit(i_reg_addr, `MSFC_ADDR_LPF_CFG))
      next_rdata = lpf_cfg;
    else
      next_rdata = 8'h00;
  end

  // Register storage
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gyro_range_filter_ctrl       <= `MSFC_RST_GYRO_CFG;
      accel_range_ctrl             <= `MSFC_RST_ACC_CFG;
      accel_filter_fifo_depth_ctrl <= `MSFC_RST_ACC_CFG2;
      rate_divider                 <= `MSFC_RST_RATE_DIV;
      lpf_cfg                      <= `MSFC_RST_LPF_CFG;
      rdata                        <= 8'h00;
      depth_chg                    <= 1'b0;
    end
    else
    begin
      gyro_range_filter_ctrl       <= next_gyro_range_filter_ctrl;
      accel_range_ctrl             <= next_accel_range_ctrl;
      accel_filter_fifo_depth_ctrl <= next_accel_filter_fifo_depth_ctrl;
      rate_divider                 <= next_rate_divider;
      lpf_cfg                      <= next_lpf_cfg;
      rdata                        <= next_rdata;
      depth_chg                    <= next_depth_chg;
    end
  end

  // Synchronise mode pins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gyro_on_s1 <= 3'h0;
      gyro_on_s2 <= 3'h0;
      lp_s1      <= 1'b0;
      lp_s2      <= 1'b0;
    end
    else
    begin
      gyro_on_s1 <= i_gyro_axis_on;
      gyro_on_s2 <= gyro_on_s1;
      lp_s1      <= i_acc_low_power;
      lp_s2      <= lp_s1;
    end
  end

  // Internal 1 kHz tick generator
  always_comb
  begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= 32'(BASE_TICK_CYC - 1))
    begin
      next_tick_cnt = 32'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // Rate source selection and divider gating
  always_comb
  begin
    gyro_fchoice = ~gyro_range_filter_ctrl[1:0];
    if (|gyro_on_s2)
      mode = MSFC_MODE_GYRO;
    else if (lp_s2)
      mode = MSFC_MODE_ACC_LP;
    else
      mode = MSFC_MODE_ACC_NORMAL;
    unique case (mode)
      MSFC_MODE_GYRO:
        div_en = (gyro_fchoice == 2'h3) && (lpf_cfg[2:0] != 3'h0) && (lpf_cfg[2:0] != 3'h7);
      MSFC_MODE_ACC_NORMAL:
        div_en = !accel_filter_fifo_depth_ctrl[3];
      MSFC_MODE_ACC_LP:
        div_en = !accel_filter_fifo_depth_ctrl[3];
    endcase
  end

  assign div_bus.enable    = div_en;
  assign div_bus.divider   = rate_divider;
  assign div_bus.base_tick = tick;

  msfc_rate_div i_msfc_rate_div (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .bus       (div_bus)
  );

  // Configuration outputs
  assign o_reg_rdata            = rdata;
  assign o_gyro_range_sel       = gyro_range_filter_ctrl[4:3];
  assign o_gyro_fchoice         = gyro_fchoice;
  assign o_acc_range_sel        = accel_range_ctrl[4:3];
  assign o_fifo_depth_sel       = accel_filter_fifo_depth_ctrl[7:6];
  assign o_fifo_depth_changed   = depth_chg;
  assign o_second_decimator_avg = 6'h04 << accel_filter_fifo_depth_ctrl[5:4];
  assign o_acc_lpf_bypass       = accel_filter_fifo_depth_ctrl[3];
  assign o_acc_bw_sel           = accel_filter_fifo_depth_ctrl[3] ? 3'h0 : accel_filter_fifo_depth_ctrl[2:0];
  assign o_gyro_selftest_en     = gyro_range_filter_ctrl[7:5];
  assign o_acc_selftest_en      = accel_range_ctrl[7:5];
  assign o_acc_duty_cycle       = (mode == MSFC_MODE_ACC_LP);
  assign o_mode                 = mode;
  assign o_rate_div_active      = div_en;
  assign o_output_data_rate_strobe = div_bus.sample;

  // Host write strobes for the gyro, accel and second accel configuration bytes only
  sequence s_gyro_wr;
    i_reg_wr && (i_reg_addr == `MSFC_ADDR_GYRO_CFG);
  endsequence
  sequence s_acc_wr;
    i_reg_wr && (i_reg_addr == `MSFC_ADDR_ACC_CFG);
  endsequence
  sequence s_acc2_wr;
    i_reg_wr && (i_reg_addr == `MSFC_ADDR_ACC_CFG2);
  endsequence

  AST_BYPASS_BW: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_acc_lpf_bypass |-> (o_acc_bw_sel == 3'h0))
    else $error("bandwidth not ignored in bypass");
  AST_GYRO_WINS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (|gyro_on_s2) |-> (o_mode == MSFC_MODE_GYRO))
    else $error("gyro mode not selected");
  AST_LP_MODE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (!(|gyro_on_s2) && lp_s2) |-> o_acc_duty_cycle)
    else $error("low power not duty cycled");
  AST_GYRO_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_gyro_wr |=> (o_gyro_range_sel == $past(i_reg_wdata[4:3])
      && o_gyro_fchoice == ~$past(i_reg_wdata[1:0])))
    else $error("gyro write mismatch");
  AST_ACC_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_acc_wr |=> (o_acc_range_sel == $past(i_reg_wdata[4:3])
      && o_acc_selftest_en == $past(i_reg_wdata[7:5])))
    else $error("accel write mismatch");
  AST_AVG: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_acc2_wr ##0 (i_reg_wdata[5:4] == 2'h3) |=> (o_second_decimator_avg == 6'h20))
    else $error("average count wrong");
  AST_DEPTH: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_acc2_wr |=> (o_fifo_depth_sel == $past(i_reg_wdata[7:6])))
    else $error("depth write mismatch");
  AST_DEPTH_CHG: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_acc2_wr ##0 (i_reg_wdata[7:6] != o_fifo_depth_sel) |=> o_fifo_depth_changed)
    else $error("depth change not flagged");
  AST_BW: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_acc2_wr ##0 !i_reg_wdata[3] |=> (o_acc_bw_sel == $past(i_reg_wdata[2:0])))
    else $error("bandwidth select wrong");
endmodule
`default_nettype wire

// [testbench/msfc_host_model.sv]
// Purpose: Host side register writer for the filter configuration block
// Assumes: A byte is taken on the rising edge while the strobe is high
// Notes:   Drives on the falling edge; old write data does not linger
`timescale 1ns/1ps
`default_nettype none
module msfc_host_model
(
  input  wire logic       i_ref_clk,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  // Idle bus at time zero
  initial
  begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // One byte write; the address stays put for read-back
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d; // Released data shows the inverse
  endtask
endmodule
`default_nettype wire

// [testbench/tb_motion_sensor_filter_config.sv]
// Purpose: Self-checking bench for the filter configuration block
// Assumes: Sample tick shortened to 10 clocks
// Notes:   The driver queues expected values and the monitor judges them
`timescale 1ns/1ps
`default_nettype none
module tb_motion_sensor_filter_config
  import msfc_pkg::*;
;
  typedef struct {int s; logic [15:0] v;} msfc_note_t;
  logic        i_ref_clk, i_sys_rst, i_reg_wr, i_acc_low_power, o_acc_lpf_bypass, o_acc_duty_cycle;
  logic        o_rate_div_active, o_output_data_rate_strobe, o_fifo_depth_changed, lp, byp, act;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, d, dv;
  logic [2:0]  i_gyro_axis_on, o_acc_bw_sel, o_gyro_selftest_en, o_acc_selftest_en, g, lpf;
  logic [1:0]  o_gyro_range_sel, o_gyro_fchoice, o_acc_range_sel, o_fifo_depth_sel, fcb, pd;
  logic [5:0]  o_second_decimator_avg;
  msfc_mode_t  o_mode;
  logic [15:0] pulses = 16'h0000;
  logic [15:0] per, exp_pulses;
  int          bad_count, samples_checked, cyc;
  msfc_note_t  notes[$];
  msfc_note_t  n;
  event        chk_ev;
  string       nm[15] = '{"rdata", "grange", "gfch", "arange", "depth", "avg", "bypass", "bw", "gst", "ast",
                          "duty", "mode", "divact", "pulses", "period"};

  msfc_top #(.BASE_TICK_CYC(10)) i_msfc_top (
    .i_ref_clk                 (i_ref_clk),
    .i_sys_rst                 (i_sys_rst),
    .i_reg_wr                  (i_reg_wr),
    .i_reg_addr                (i_reg_addr),
    .i_reg_wdata               (i_reg_wdata),
    .o_reg_rdata               (o_reg_rdata),
    .i_gyro_axis_on            (i_gyro_axis_on),
    .i_acc_low_power           (i_acc_low_power),
    .o_gyro_range_sel          (o_gyro_range_sel),
    .o_gyro_fchoice            (o_gyro_fchoice),
    .o_acc_range_sel           (o_acc_range_sel),
    .o_fifo_depth_sel          (o_fifo_depth_sel),
    .o_second_decimator_avg    (o_second_decimator_avg),
    .o_acc_lpf_bypass          (o_acc_lpf_bypass),
    .o_acc_bw_sel              (o_acc_bw_sel),
    .o_gyro_selftest_en        (o_gyro_selftest_en),
    .o_acc_selftest_en         (o_acc_selftest_en),
    .o_acc_duty_cycle          (o_acc_duty_cycle),
    .o_mode                    (o_mode),
    .o_rate_div_active         (o_rate_div_active),
    .o_output_data_rate_strobe (o_output_data_rate_strobe),
    .o_fifo_depth_changed      (o_fifo_depth_changed)
  );
  msfc_host_model i_msfc_host_model (.i_ref_clk(i_ref_clk), .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr),
                                     .o_reg_wdata(i_reg_wdata));

  // Clock at 100 MHz
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return 16'(o_reg_rdata);
      1: return 16'(o_gyro_range_sel);
      2: return 16'(o_gyro_fchoice);
      3: return 16'(o_acc_range_sel);
      4: return 16'(o_fifo_depth_sel);
      5: return 16'(o_second_decimator_avg);
      6: return 16'(o_acc_lpf_bypass);
      7: return 16'(o_acc_bw_sel);
      8: return 16'(o_gyro_selftest_en);
      9: return 16'(o_acc_selftest_en);
      10: return 16'(o_acc_duty_cycle);
      11: return 16'(o_mode);
      12: return 16'(o_rate_div_active);
      13: return pulses;
      default: return per;
    endcase
  endfunction

  task automatic note(input int s, input logic [15:0] v);
    notes.push_back('{s, v});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_msfc_host_model.put(a, v);
    @(negedge i_ref_clk);
  endtask
  task automatic go;
    -> chk_ev;
    #1;
  endtask
  task automatic done(input string t);
    go();
    $display("test %s finished", t);
  endtask
  // Partial interval up to the first strobe, then one whole strobe interval that is kept
  task automatic measure;
    repeat (2)
    begin
      per = 16'h0000;
      do
      begin
        @(negedge i_ref_clk);
        per++;
      end
      while (o_output_data_rate_strobe !== 1'b1 && per < 16'd2000);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Monitor: takes every queued note, oldest first, and compares it with the outputs
  initial
  forever
  begin
    @(chk_ev);
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      samples_checked++;
      if (obs(n.s) !== n.v)
      begin
        bad_count++;
        $display("unexpected %s expected %0h seen %0h", nm[n.s], n.v, obs(n.s));
      end
    end
  end

  // Depth-change pulse counter and hang guard
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (o_fifo_depth_changed === 1'b1)
      pulses <= pulses + 16'h0001;
    if (cyc == 6000)
    begin
      bad_count++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    i_sys_rst = 1'b1;
    i_gyro_axis_on = 3'h0;
    i_acc_low_power = 1'b0;
    exp_pulses = 16'h0000;
    pd = 2'h0;
    void'($urandom(60881));
    repeat (4) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    note(2, 16'h0003);
    note(5, 16'h0004);
    note(11, 16'(MSFC_MODE_ACC_NORMAL));
    done("reset");
    for (int c = 0; c < 4; c++)
    begin
      d = (8'($urandom) & 8'hE7) | 8'(c << 3);
      wr(8'h1B, d);
      note(1, 16'(c));
      note(2, {14'h0000, ~d[1:0]});
      note(8, 16'(d[7:5]));
      note(0, 16'(d & 8'hFB));
      go();
      d = (8'($urandom) & 8'hE7) | 8'(c << 3);
      wr(8'h1C, d);
      note(3, 16'(c));
      note(9, 16'(d[7:5]));
      note(0, 16'(d & 8'hF8));
      go();
    end
    done("ranges");
    for (int i = 0; i < 8; i++)
    begin
      d = (8'($urandom) & 8'h37) | 8'(i[2:1] << 6) | 8'(i[0] << 3);
      wr(8'h1D, d);
      if (d[7:6] != pd)
        exp_pulses++;
      pd = d[7:6];
      note(4, 16'(d[7:6]));
      note(13, exp_pulses);
      note(5, 16'h0004 << d[5:4]);
      note(6, 16'(d[3]));
      note(7, 16'(d[3] ? 3'h0 : d[2:0]));
      note(0, 16'(d));
      go();
    end
    done("filter");
    wr(8'h2A, 8'hFF);
    note(0, 16'h0000);
    note(1, 16'h0003);
    done("unmapped");
    for (int i = 0; i < 8; i++)
    begin
      g = i[2] ? 3'h0 : 3'($urandom_range(7, 1));
      lp = i[0];
      byp = i[1];
      fcb = i[1] ? 2'($urandom) : 2'h0;
      lpf = 3'($urandom);
      dv = 8'($urandom_range(3, 0));
      i_gyro_axis_on = g;
      i_acc_low_power = lp;
      wr(8'h1B, {6'h00, fcb});
      wr(8'h1A, {5'h00, lpf});
      wr(8'h1D, {4'h0, byp, 3'h0});
      wr(8'h19, dv);
      act = (g != 3'h0) ? (fcb == 2'h0 && lpf != 3'h0 && lpf != 3'h7) : !byp;
      measure();
      note(11, 16'((g != 3'h0) ? MSFC_MODE_GYRO : lp ? MSFC_MODE_ACC_LP : MSFC_MODE_ACC_NORMAL));
      note(10, 16'(g == 3'h0 && lp));
      note(12, 16'(act));
      note(14, act ? 16'd10 * (16'(dv) + 16'd1) : 16'd10);
      go();
    end
    done("rate");
    // Second reset in mid-run brings the stored fields back
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    note(1, 16'h0000);
    note(2, 16'h0003);
    note(4, 16'h0000);
    note(5, 16'h0004);
    note(11, 16'(MSFC_MODE_ACC_LP));
    note(0, 16'h0000);
    done("reset again");
    results();
  end
endmodule
`default_nettype wire
